/* rtl/vint_pkg.sv */
package vint_pkg;
  // Register addresses in data memory space
  localparam logic [6:0] ADDR_FLAGS_A = 7'h0b;
  localparam logic [6:0] ADDR_FLAGS_B = 7'h1e;
  // Field positions, first control register
  localparam int BIT_MASTER_EN = 0;
  localparam int BIT_EXT0_EN   = 1;
  localparam int BIT_EXT1_EN   = 2;
  localparam int BIT_TIMER_EN  = 3;
  localparam int BIT_EXT0_FLAG = 4;
  localparam int BIT_EXT1_FLAG = 5;
  localparam int BIT_TIMER_FLAG = 6;
  // Field positions, second control register
  localparam int BIT_TB_EN     = 0;
  localparam int BIT_RTC_EN    = 1;
  localparam int BIT_TB_FLAG   = 4;
  localparam int BIT_RTC_FLAG  = 5;
  // Reset values
  localparam logic [7:0] RESET_FLAGS_A = 8'h00;
  localparam logic [7:0] RESET_FLAGS_B = 8'h00;
  // Sources in priority order, index 0 highest
  localparam int NUM_SRC = 5;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_EXT1 = 1;
  localparam int SRC_TIMER = 2;
  localparam int SRC_TB = 3;
  localparam int SRC_RTC = 4;
  // Vector addresses
  localparam logic [9:0] VEC_EXT0  = 10'h004;
  localparam logic [9:0] VEC_EXT1  = 10'h008;
  localparam logic [9:0] VEC_TIMER = 10'h00c;
  localparam logic [9:0] VEC_TB    = 10'h010;
  localparam logic [9:0] VEC_RTC   = 10'h014;
  // Return stack
  localparam int STACK_DEPTH = 4;
  localparam logic [2:0] STACK_FULL_LEVEL = 3'h4;
  localparam logic [2:0] RESET_STACK_INDEX = 3'h0;
  localparam logic [9:0] RESET_PC = 10'h000;
endpackage : vint_pkg

/* rtl/vint_edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// Two-stage synchroniser with falling edge detect on the second stage
module vint_edge_sync (
  input  wire logic i_mclk,
  input  wire logic i_rst_b,
  input  wire logic i_pin,
  output logic      o_fall
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic fall;
  } vint_es_t;
  vint_es_t s;
  vint_es_t next_s;

  always_comb begin
    next_s      = s;
    next_s.meta = i_pin;
    next_s.sync = s.meta;
    next_s.prev = s.sync;
    next_s.fall = s.prev & ~s.sync;
  end

  // Reset to high so an idle-high pin gives no false edge
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= 4'hf & {1'b1, 1'b1, 1'b1, 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign o_fall = s.fall;
endmodule : vint_edge_sync
`default_nettype wire

/* rtl/vint_prio.sv */
`timescale 1ns/1ps
`default_nettype none
// Fixed priority pick, lowest index wins
module vint_prio (
  input  wire logic [4:0] i_req,
  output logic      [4:0] o_grant,
  output logic      [9:0] o_vector
);
  always_comb begin
    o_grant  = 5'h00;
    o_vector = vint_pkg::VEC_EXT0;
    if (i_req[vint_pkg::SRC_EXT0]) begin
      o_grant[vint_pkg::SRC_EXT0] = 1'b1;
      o_vector = vint_pkg::VEC_EXT0;
    end else if (i_req[vint_pkg::SRC_EXT1]) begin
      o_grant[vint_pkg::SRC_EXT1] = 1'b1;
      o_vector = vint_pkg::VEC_EXT1;
    end else if (i_req[vint_pkg::SRC_TIMER]) begin
      o_grant[vint_pkg::SRC_TIMER] = 1'b1;
      o_vector = vint_pkg::VEC_TIMER;
    end else if (i_req[vint_pkg::SRC_TB]) begin
      o_grant[vint_pkg::SRC_TB] = 1'b1;
      o_vector = vint_pkg::VEC_TB;
    end else if (i_req[vint_pkg::SRC_RTC]) begin
      o_grant[vint_pkg::SRC_RTC] = 1'b1;
      o_vector = vint_pkg::VEC_RTC;
    end
  end
endmodule : vint_prio
`default_nettype wire

/* rtl/vint_unit.sv */
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Five sources: two pins, timer, time base, clock
// - Pin falling edge sets its request flag
// - Acknowledge clears master enable; flags still record
// - Full stack inhibits acknowledge until a return
// - Only program counter pushed, then jump vector
// - External sources vector to 04H and 08H
// - Timer overflow flag bit 6, vector 0CH
// - Time base flag bit 4, vector 10H
// - Clock tick flag bit 5, vector 14H
// - Interrupt return sets master enable; plain return not
// - Software re-enable during service permits nesting
// - Requests sampled and serviced at phase pulse
// - Fixed priority, external 0 highest, clock lowest
// - First register holds enables and three flags
// - Second register holds two enables and flags
// - Flags stay until serviced or software cleared
// - Any pending source wakes from halt
// - Return stack has four levels
module vint_unit (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_ext_irq_pin_0,
  input  wire logic       i_ext_irq_pin_1,
  input  wire logic       i_timer_ovf,
  input  wire logic       i_timebase_tick,
  input  wire logic       i_rtc_tick,
  input  wire logic       i_second_cycle_phase,
  input  wire logic       i_call,
  input  wire logic       i_ret,
  input  wire logic       i_return_from_irq_instr,
  input  wire logic [9:0] i_program_counter,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [6:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rd_hit,
  output logic            o_ack,
  output logic      [9:0] o_vector,
  output logic      [9:0] o_return_addr,
  output logic      [2:0] o_stack_index,
  output logic            o_stack_full,
  output logic            o_wake,
  output logic      [7:0] o_irq_enable_flags_a,
  output logic      [7:0] o_irq_enable_flags_b
);

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic       master_irq_enable;
    logic       ext0_irq_enable;
    logic       ext1_irq_enable;
    logic       timer_irq_enable;
    logic       timebase_irq_enable;
    logic       rtc_irq_enable;
    logic [4:0] flags;
    logic       phase_prev;
    logic [2:0] stack_index;
    logic [3:0][9:0] stack;
    logic [7:0] rdata;
    logic       rd_hit;
    logic       ack;
    logic [9:0] vector;
    logic [9:0] return_addr;
    logic       wake;
    logic       stack_full;
    logic [7:0] image_a;
    logic [7:0] image_b;
  } vint_state_t;

  vint_state_t s;
  vint_state_t next_s;

  logic       ext0_fall;
  logic       ext1_fall;
  logic [4:0] events;
  logic [4:0] enables;
  logic [4:0] grant;
  logic [9:0] grant_vector;
  logic [4:0] candidates;

  function automatic logic [7:0] pack_a(input vint_state_t st);
    logic [7:0] r;
    r = 8'h00;
    r[vint_pkg::BIT_MASTER_EN]  = st.master_irq_enable;
    r[vint_pkg::BIT_EXT0_EN]    = st.ext0_irq_enable;
    r[vint_pkg::BIT_EXT1_EN]    = st.ext1_irq_enable;
    r[vint_pkg::BIT_TIMER_EN]   = st.timer_irq_enable;
    r[vint_pkg::BIT_EXT0_FLAG]  = st.flags[vint_pkg::SRC_EXT0];
    r[vint_pkg::BIT_EXT1_FLAG]  = st.flags[vint_pkg::SRC_EXT1];
    r[vint_pkg::BIT_TIMER_FLAG] = st.flags[vint_pkg::SRC_TIMER];
    return r;
  endfunction

  function automatic logic [7:0] pack_b(input vint_state_t st);
    logic [7:0] r;
    r = 8'h00;
    r[vint_pkg::BIT_TB_EN]    = st.timebase_irq_enable;
    r[vint_pkg::BIT_RTC_EN]   = st.rtc_irq_enable;
    r[vint_pkg::BIT_TB_FLAG]  = st.flags[vint_pkg::SRC_TB];
    r[vint_pkg::BIT_RTC_FLAG] = st.flags[vint_pkg::SRC_RTC];
    return r;
  endfunction

  // ==========================================================
  // Pin edge detect and priority pick
  // ==========================================================
  vint_edge_sync u_sync0 (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_ext_irq_pin_0),
    .o_fall  (ext0_fall)
  );

  vint_edge_sync u_sync1 (
    .i_mclk  (i_mclk),
    .i_rst_b (i_rst_b),
    .i_pin   (i_ext_irq_pin_1),
    .o_fall  (ext1_fall)
  );

  assign events = {i_rtc_tick, i_timebase_tick, i_timer_ovf,
                   ext1_fall, ext0_fall};
  assign enables = {s.rtc_irq_enable, s.timebase_irq_enable,
                    s.timer_irq_enable, s.ext1_irq_enable,
                    s.ext0_irq_enable};
  // Raised flags whose source enable is set are eligible now
  assign candidates = s.flags & enables;

  vint_prio u_prio (
    .i_req    (candidates),
    .o_grant  (grant),
    .o_vector (grant_vector)
  );

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    logic phase_rise;
    logic do_ack;
    logic stack_full;
    logic wr_a;
    logic wr_b;
    phase_rise = 1'b0;
    do_ack     = 1'b0;
    stack_full = 1'b0;
    wr_a       = 1'b0;
    wr_b       = 1'b0;
    next_s     = s;
    next_s.ack = 1'b0;
    next_s.rd_hit = 1'b0;

    phase_rise = i_second_cycle_phase & ~s.phase_prev;
    next_s.phase_prev = i_second_cycle_phase;
    stack_full = (s.stack_index == vint_pkg::STACK_FULL_LEVEL);

    wr_a = i_wr_en && (i_addr == vint_pkg::ADDR_FLAGS_A);
    wr_b = i_wr_en && (i_addr == vint_pkg::ADDR_FLAGS_B);

    // Software writes come first so hardware sets win over them
    if (wr_a) begin
      next_s.master_irq_enable = i_wdata[vint_pkg::BIT_MASTER_EN];
      next_s.ext0_irq_enable   = i_wdata[vint_pkg::BIT_EXT0_EN];
      next_s.ext1_irq_enable   = i_wdata[vint_pkg::BIT_EXT1_EN];
      next_s.timer_irq_enable  = i_wdata[vint_pkg::BIT_TIMER_EN];
      next_s.flags[vint_pkg::SRC_EXT0] =
        i_wdata[vint_pkg::BIT_EXT0_FLAG];
      next_s.flags[vint_pkg::SRC_EXT1] =
        i_wdata[vint_pkg::BIT_EXT1_FLAG];
      next_s.flags[vint_pkg::SRC_TIMER] =
        i_wdata[vint_pkg::BIT_TIMER_FLAG];
    end
    if (wr_b) begin
      next_s.timebase_irq_enable = i_wdata[vint_pkg::BIT_TB_EN];
      next_s.rtc_irq_enable      = i_wdata[vint_pkg::BIT_RTC_EN];
      next_s.flags[vint_pkg::SRC_TB]  = i_wdata[vint_pkg::BIT_TB_FLAG];
      next_s.flags[vint_pkg::SRC_RTC] = i_wdata[vint_pkg::BIT_RTC_FLAG];
    end

    // Acknowledge only on a phase pulse, master on, stack not full
    if (phase_rise && s.master_irq_enable && !stack_full &&
        (candidates != 5'h00)) begin
      do_ack = 1'b1;
    end

    // Returns pop the stack; interrupt return re-arms master
    if (i_ret || i_return_from_irq_instr) begin
      if (s.stack_index != vint_pkg::RESET_STACK_INDEX) begin
        next_s.stack_index = s.stack_index - 3'h1;
      end
    end
    if (i_return_from_irq_instr) begin
      next_s.master_irq_enable = 1'b1;
    end

    if (do_ack) begin
      next_s.master_irq_enable = 1'b0;
      next_s.flags  = next_s.flags & ~grant;
      next_s.stack[s.stack_index[1:0]] = i_program_counter;
      next_s.stack_index = s.stack_index + 3'h1;
      next_s.ack    = 1'b1;
      next_s.vector = grant_vector;
      next_s.return_addr = i_program_counter;
    end else if (i_call) begin
      // A call on a full stack overwrites the oldest entry
      next_s.stack[s.stack_index[1:0]] = i_program_counter;
      if (!stack_full) begin
        next_s.stack_index = s.stack_index + 3'h1;
      end
    end
    if ((i_ret || i_return_from_irq_instr) && !do_ack &&
        s.stack_index != vint_pkg::RESET_STACK_INDEX) begin
      next_s.return_addr = s.stack[2'(s.stack_index - 3'h1)];
    end

    // Hardware sets win over a same-cycle clear
    next_s.flags = next_s.flags | events;

    // Any pending flag wakes the core regardless of masking
    next_s.wake = (s.flags != 5'h00);

    if (i_rd_en) begin
      if (i_addr == vint_pkg::ADDR_FLAGS_A) begin
        next_s.rdata  = pack_a(s);
        next_s.rd_hit = 1'b1;
      end else if (i_addr == vint_pkg::ADDR_FLAGS_B) begin
        next_s.rdata  = pack_b(s);
        next_s.rd_hit = 1'b1;
      end else begin
        next_s.rdata = 8'h00;
      end
    end

    // Register images kept in flops so the outputs leave a flop
    next_s.stack_full =
      (next_s.stack_index == vint_pkg::STACK_FULL_LEVEL);
    next_s.image_a = pack_a(next_s);
    next_s.image_b = pack_b(next_s);
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign o_rdata              = s.rdata;
  assign o_rd_hit             = s.rd_hit;
  assign o_ack                = s.ack;
  assign o_vector             = s.vector;
  assign o_return_addr        = s.return_addr;
  assign o_stack_index        = s.stack_index;
  assign o_stack_full         = s.stack_full;
  assign o_wake               = s.wake;
  assign o_irq_enable_flags_a = s.image_a;
  assign o_irq_enable_flags_b = s.image_b;

endmodule : vint_unit
`default_nettype wire

/* dv/vint_unit_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module vint_unit_properties (
  input wire logic       i_mclk,
  input wire logic       i_rst_b,
  input wire logic       i_second_cycle_phase,
  input wire logic       i_ret,
  input wire logic       i_return_from_irq_instr,
  input wire logic       i_wr_en,
  input wire logic       i_rd_en,
  input wire logic [6:0] i_addr,
  input wire logic [9:0] i_program_counter,
  input wire logic       o_rd_hit,
  input wire logic       o_ack,
  input wire logic [9:0] o_vector,
  input wire logic [9:0] o_return_addr,
  input wire logic [2:0] o_stack_index,
  input wire logic       o_stack_full,
  input wire logic [7:0] o_irq_enable_flags_a,
  input wire logic [7:0] o_irq_enable_flags_b
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  wire logic [7:0] fa = o_irq_enable_flags_a;
  wire logic [7:0] fb = o_irq_enable_flags_b;
  // ==========================================
  // Acknowledge
  property p_ack_phase;
    o_ack |-> $past(i_second_cycle_phase) && !$past(i_second_cycle_phase, 2);
  endproperty
  a_ack_phase: assert property (p_ack_phase)
    else $error("ack away from a phase rise");
  property p_ack_vec;
    o_ack |-> o_vector inside {10'h004, 10'h008, 10'h00c, 10'h010, 10'h014};
  endproperty
  a_ack_vec: assert property (p_ack_vec)
    else $error("ack with illegal vector");
  property p_ack_master;
    o_ack |-> !fa[0];
  endproperty
  a_ack_master: assert property (p_ack_master)
    else $error("master enable left set by ack");
  property p_ack_push;
    o_ack |-> o_return_addr == $past(i_program_counter)
      && o_stack_index == $past(o_stack_index) + 3'h1;
  endproperty
  a_ack_push: assert property (p_ack_push)
    else $error("ack push wrong");
  property p_full_block;
    o_stack_full && !i_ret && !i_return_from_irq_instr |=> !o_ack;
  endproperty
  a_full_block: assert property (p_full_block)
    else $error("ack with stack full");
  property p_full_dec;
    o_stack_full == (o_stack_index == 3'h4) && o_stack_index <= 3'h4;
  endproperty
  a_full_dec: assert property (p_full_dec)
    else $error("stack level or full flag wrong");
  property p_rd_hit;
    o_rd_hit == $past(i_rd_en && (i_addr == 7'h0b || i_addr == 7'h1e));
  endproperty
  a_rd_hit: assert property (p_rd_hit)
    else $error("read hit wrong");
  property p_reserved;
    !fa[7] && fb[7:6] == 2'h0 && fb[3:2] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("unused bit set");
  property p_return_from_irq_instr_master;
    $past(i_return_from_irq_instr) && $past(o_stack_index) != 3'h0 && !$past(i_wr_en)
      && !o_ack |-> fa[0];
  endproperty
  a_return_from_irq_instr_master: assert property (p_return_from_irq_instr_master)
    else $error("interrupt return left master off");
  property p_ret_master;
    $past(i_ret) && !$past(i_return_from_irq_instr) && !$past(i_wr_en) && !o_ack
      |-> fa[0] == $past(fa[0]);
  endproperty
  a_ret_master: assert property (p_ret_master)
    else $error("plain return changed master");
  property p_flag_sticky;
    $past(fa[6]) && !o_ack && !$past(i_wr_en) |-> fa[6];
  endproperty
  a_flag_sticky: assert property (p_flag_sticky)
    else $error("request flag lost");
  c_last_vec: cover property (o_ack && o_vector == 10'h014);
  c_full_ret: cover property (o_stack_full && i_ret ##[1:12] o_ack);
  c_rd_hit: cover property (o_rd_hit);
endmodule // vint_unit_properties
bind vint_unit vint_unit_properties vint_unit_properties_inst (.*);
`default_nettype wire

/* dv/vint_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vint_core_model (
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_ack,
  output logic            o_phase,
  output logic      [9:0] o_program_counter
);
  logic [1:0] cnt;
  // ==========================================
  // Phase rises once per four-clock machine cycle
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= 2'h0;
      o_phase <= 1'b0;
      o_program_counter <= 10'h000;
    end else begin
      cnt <= cnt + 2'h1;
      o_phase <= (cnt == 2'h1);
      // Moves only after an ack, so the pushed value is stable long before
      if (i_ack) begin
        o_program_counter <= o_program_counter + 10'h001;
      end
    end
  end
endmodule // vint_core_model
`default_nettype wire

/* dv/test_vint_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
  checks++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("mismatch at %0t: got %h expected %h", $time, g, e); \
  end \
end
module test_vint_unit;
  logic       i_mclk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       i_ext_irq_pin_0 = 1'b1;
  logic       i_ext_irq_pin_1 = 1'b1;
  logic       i_timer_ovf = 1'b0;
  logic       i_timebase_tick = 1'b0;
  logic       i_rtc_tick = 1'b0;
  logic       i_call = 1'b0;
  logic       i_ret = 1'b0;
  logic       i_return_from_irq_instr = 1'b0;
  logic       i_wr_en = 1'b0;
  logic       i_rd_en = 1'b0;
  logic [6:0] i_addr = 7'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_second_cycle_phase, o_rd_hit, o_ack, o_stack_full, o_wake;
  logic [9:0] i_program_counter, o_vector, o_return_addr;
  logic [7:0] o_rdata, o_irq_enable_flags_a, o_irq_enable_flags_b;
  logic [2:0] o_stack_index;
  int         miscompares = 0;
  int         checks = 0;
  int         nacks = 0;
  bit         got;
  logic       fbit;
  always #4 i_mclk = ~i_mclk;
  vint_unit vint_unit_inst (.*);
  vint_core_model vint_core_model_inst (.i_mclk(i_mclk), .i_rst_b(i_rst_b),
    .i_ack(o_ack), .o_phase(i_second_cycle_phase),
    .o_program_counter(i_program_counter));
  // ==========================================
  // Bus and event helpers
  task tick;
    @(posedge i_mclk);
    #1;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] d);
    i_addr = a;
    i_wdata = d;
    i_wr_en = 1'b1;
    tick();
    i_wr_en = 1'b0;
    tick();
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e, input logic h);
    i_addr = a;
    i_rd_en = 1'b1;
    tick();
    i_rd_en = 1'b0;
    `CHK(o_rdata, e)
    `CHK(o_rd_hit, h)
    tick();
  endtask
  task cpu(input int k);
    case (k)
      0: i_call = 1'b1;
      1: i_ret = 1'b1;
      default: i_return_from_irq_instr = 1'b1;
    endcase
    tick();
    {i_call, i_ret, i_return_from_irq_instr} = 3'b000;
    tick();
  endtask
  task fire(input int s);
    case (s)
      0: i_ext_irq_pin_0 = 1'b0;
      1: i_ext_irq_pin_1 = 1'b0;
      2: i_timer_ovf = 1'b1;
      3: i_timebase_tick = 1'b1;
      default: i_rtc_tick = 1'b1;
    endcase
    tick();
    {i_timer_ovf, i_timebase_tick, i_rtc_tick} = 3'b000;
    tick();
    {i_ext_irq_pin_0, i_ext_irq_pin_1} = 2'b11;
  endtask
  // The ack may already stand when the wait begins
  task wait_ack(input int lim);
    got = (o_ack === 1'b1);
    for (int i = 0; i < lim && !got; i++) begin
      tick();
      got = (o_ack === 1'b1);
    end
    if (got) nacks++;
  endtask
  // ==========================================
  // Scenarios
  task t_regs;
    rd(7'h0b, 8'h00, 1'b1);
    rd(7'h1e, 8'h00, 1'b1);
    rd(7'h0c, 8'h00, 1'b0);
    wr(7'h0b, 8'h8e);
    rd(7'h0b, 8'h0e, 1'b1);
    wr(7'h1e, 8'hcf);
    rd(7'h1e, 8'h03, 1'b1);
  endtask
  task t_prio;
    for (int s = 0; s < 5; s++) fire(s);
    wait_ack(16);
    `CHK(got, 1'b0)
    `CHK(o_irq_enable_flags_a, 8'h7e)
    `CHK(o_irq_enable_flags_b, 8'h33)
    `CHK(o_wake, 1'b1)
    wr(7'h0b, 8'h7f);
    for (int s = 0; s < 5; s++) begin
      wait_ack(24);
      `CHK(got, 1'b1)
      `CHK(o_vector, 10'(4 * (s + 1)))
      `CHK(o_return_addr, 10'(nacks - 1))
      `CHK(o_stack_index, 3'h1)
      fbit = (s < 3) ? o_irq_enable_flags_a[s + 4]
                     : o_irq_enable_flags_b[s + 1];
      `CHK(fbit, 1'b0)
      cpu(2);
    end
  endtask
  task t_full;
    repeat (4) cpu(0);
    `CHK(o_stack_full, 1'b1)
    fire(2);
    wait_ack(20);
    `CHK(got, 1'b0)
    `CHK(o_irq_enable_flags_a[6], 1'b1)
    cpu(1);
    wait_ack(20);
    `CHK(got, 1'b1)
    `CHK(o_vector, 10'h00c)
    `CHK(o_stack_index, 3'h4)
    repeat (4) cpu(1);
    `CHK(o_stack_index, 3'h0)
    `CHK(o_return_addr, 10'h005)
    `CHK(o_irq_enable_flags_a[0], 1'b0)
  endtask
  task wrap_up;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge i_mclk);
    #1 i_rst_b = 1'b1;
    repeat (4) tick();
    t_regs();
    t_prio();
    t_full();
    wrap_up();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule // test_vint_unit
`default_nettype wire
